// ==== verilog/sipu_pkg.sv ====
// Operation
// - Table and task loads, control, debug, cache, halt, return, MSR ops need privilege zero
// - Table and task stores, status store, verify ops, bus lock: any privilege
// - At any privilege above zero, two feature flags gate the counter reads
// - Counter-read-restrict set: cycle counter read only at privilege zero
// - Perf-counter-open set: event counter read at any privilege, else zero
// - Global/vector table load takes base and limit from memory
// - Global/vector table store writes base and limit to memory
// - Local table load takes selector and its descriptor
// - Local table store writes only the selector
// - Task register load takes selector and task segment descriptor
// - Task register store writes the current task selector
// - Status word load/store touch only bits 0 to 15
// - Floating-point op with task-switched flag set raises fpu fault
// - Clear switch flag clears the task-switched flag
// - Control move copies a whole control register either way, five registers
// - Feature query reports implemented feature flags, perf-counter-open excluded
package sipu_pkg;
	// ---------------------------------------------------------------
	// Operation codes
	// ---------------------------------------------------------------
	localparam int         OP_W        = 5;
	localparam logic [4:0] OP_LD_LOCAL = 5'h00;
	localparam logic [4:0] OP_ST_LOCAL = 5'h01;
	localparam logic [4:0] OP_LD_GLOB  = 5'h02;
	localparam logic [4:0] OP_ST_GLOB  = 5'h03;
	localparam logic [4:0] OP_LD_VECT  = 5'h04;
	localparam logic [4:0] OP_ST_VECT  = 5'h05;
	localparam logic [4:0] OP_LD_TASK  = 5'h06;
	localparam logic [4:0] OP_ST_TASK  = 5'h07;
	localparam logic [4:0] OP_CR_LOAD  = 5'h08;
	localparam logic [4:0] OP_CR_STORE = 5'h09;
	localparam logic [4:0] OP_LD_MSW   = 5'h0a;
	localparam logic [4:0] OP_ST_MSW   = 5'h0b;
	localparam logic [4:0] OP_CLR_SW   = 5'h0c;
	localparam logic [4:0] OP_ADJ_RPL  = 5'h0d;
	localparam logic [4:0] OP_LD_AR    = 5'h0e;
	localparam logic [4:0] OP_LD_LIM   = 5'h0f;
	localparam logic [4:0] OP_VER_RD   = 5'h10;
	localparam logic [4:0] OP_VER_WR   = 5'h11;
	localparam logic [4:0] OP_DBG_MOVE = 5'h12;
	localparam logic [4:0] OP_INV_NWB  = 5'h13;
	localparam logic [4:0] OP_INV_WB   = 5'h14;
	localparam logic [4:0] OP_INV_PAGE = 5'h15;
	localparam logic [4:0] OP_HALT     = 5'h16;
	localparam logic [4:0] OP_LOCK     = 5'h17;
	localparam logic [4:0] OP_SMM_RET  = 5'h18;
	localparam logic [4:0] OP_MSR_RD   = 5'h19;
	localparam logic [4:0] OP_MSR_WR   = 5'h1a;
	localparam logic [4:0] OP_EVT_RD   = 5'h1b;
	localparam logic [4:0] OP_CYC_RD   = 5'h1c;
	localparam logic [4:0] OP_FPU      = 5'h1d;
	localparam logic [4:0] OP_FEAT_Q   = 5'h1e;
	// ---------------------------------------------------------------
	// Control word fields and reset values
	// ---------------------------------------------------------------
	localparam int          NUM_CR       = 5;
	localparam int          TS_BIT       = 3;
	localparam int          TSD_BIT      = 2;
	localparam int          PCE_BIT      = 8;
	localparam int          MSW_W        = 16;
	localparam int          FEAT_HI      = 10;
	localparam logic [31:0] CR0_RST      = 32'h0000_0010;
	localparam logic [31:0] CR_RST       = 32'h0000_0000;
	localparam logic [31:0] FEAT_DEF     = 32'h0000_07ff;
	// ---------------------------------------------------------------
	// APB map
	// ---------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  A_STATUS     = 8'h00;
	localparam logic [7:0]  A_MASK       = 8'h04;
	localparam logic [7:0]  A_CR0        = 8'h08;
	localparam logic [7:0]  A_CR4        = 8'h0c;
	localparam logic [7:0]  A_FEAT       = 8'h10;
	localparam int          EV_W         = 3;
	localparam int          EV_DONE      = 0;
	localparam int          EV_GP        = 1;
	localparam int          EV_NM        = 2;
endpackage : sipu_pkg

// ==== verilog/sipu_priv_check.sv ====
`timescale 1ns/1ns
`default_nettype none
module sipu_priv_check (
	// Operation
	input  wire logic [4:0]  i_op,
	input  wire logic [1:0]  i_cpl,
	input  wire logic [31:0] i_cr4,
	// Verdict
	output logic             o_allow
);
	logic at_zero;

	always_comb begin
		at_zero = (i_cpl == 2'h0);
		case (i_op)
			sipu_pkg::OP_LD_LOCAL, sipu_pkg::OP_LD_GLOB, sipu_pkg::OP_LD_VECT,
			sipu_pkg::OP_LD_TASK, sipu_pkg::OP_CR_LOAD, sipu_pkg::OP_CR_STORE,
			sipu_pkg::OP_LD_MSW, sipu_pkg::OP_CLR_SW, sipu_pkg::OP_DBG_MOVE,
			sipu_pkg::OP_INV_NWB, sipu_pkg::OP_INV_WB, sipu_pkg::OP_INV_PAGE,
			sipu_pkg::OP_HALT, sipu_pkg::OP_SMM_RET, sipu_pkg::OP_MSR_RD,
			sipu_pkg::OP_MSR_WR: begin
				o_allow = at_zero;
			end
			sipu_pkg::OP_CYC_RD: begin
				o_allow = !i_cr4[sipu_pkg::TSD_BIT] || at_zero;
			end
			sipu_pkg::OP_EVT_RD: begin
				o_allow = i_cr4[sipu_pkg::PCE_BIT] || at_zero;
			end
			default: begin
				o_allow = 1'b1;
			end
		endcase
	end
endmodule : sipu_priv_check
`default_nettype wire

// ==== verilog/sipu_top.sv ====
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sipu_top #(
	parameter logic [31:0] P_FEAT_IMPL = sipu_pkg::FEAT_DEF
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Operation request
	input  wire logic        i_op_valid,
	input  wire logic [4:0]  i_op,
	input  wire logic [1:0]  i_cpl,
	input  wire logic [2:0]  i_cr_idx,
	input  wire logic [63:0] i_operand,
	input  wire logic [63:0] i_desc,
	// Operation answer
	output logic             o_op_done,
	output logic             o_gp_fault,
	output logic             o_nm_fault,
	output logic [63:0]      o_result,
	output logic [31:0]      o_cr0,
	output logic [31:0]      o_cr4,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Interrupt
	output logic             o_irq
);
	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (P_FEAT_IMPL[31:sipu_pkg::FEAT_HI+1] != '0) begin : g_bad_feat
		$error("P_FEAT_IMPL names flags beyond the feature word");
	end
	// Package fields must fit the words they index
	if (sipu_pkg::NUM_CR > 8) begin : g_bad_num_cr
		$error("control register count exceeds the index width");
	end
	if (sipu_pkg::PCE_BIT > sipu_pkg::FEAT_HI || sipu_pkg::TSD_BIT > sipu_pkg::FEAT_HI) begin : g_bad_flag
		$error("counter flags lie outside the feature word");
	end
	if (sipu_pkg::MSW_W != 16 || sipu_pkg::TS_BIT >= sipu_pkg::MSW_W) begin : g_bad_msw
		$error("status word fields do not fit the machine control word");
	end
	if (sipu_pkg::EV_W != 3) begin : g_bad_ev
		$error("event status width does not match the three event sources");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [31:0] cr_q [sipu_pkg::NUM_CR];
	logic [31:0] cr_d [sipu_pkg::NUM_CR];
	logic [31:0] glob_base_q, glob_base_d;
	logic [15:0] glob_lim_q, glob_lim_d;
	logic [31:0] vect_base_q, vect_base_d;
	logic [15:0] vect_lim_q, vect_lim_d;
	logic [15:0] loc_sel_q, loc_sel_d;
	logic [63:0] loc_desc_q, loc_desc_d;
	logic [15:0] task_sel_q, task_sel_d;
	logic [63:0] task_desc_q, task_desc_d;
	logic [63:0] result_q, result_d;
	logic        done_q, done_d;
	logic        gp_q, gp_d;
	logic        nm_q, nm_d;
	logic [2:0]  stat_q, stat_d;
	logic [2:0]  mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic        allow;
	logic        cr_ok;
	logic        apb_wr;
	logic        apb_rd;
	logic [2:0]  events;
	logic [31:0] feat_word;
	logic        addr_ok;

	sipu_priv_check u_priv (
		.i_op    (i_op),
		.i_cpl   (i_cpl),
		.i_cr4   (cr_q[4]),
		.o_allow (allow)
	);

	assign cr_ok     = (i_cr_idx < 3'(sipu_pkg::NUM_CR));
	assign apb_wr    = i_psel && i_penable && i_pwrite;
	assign apb_rd    = i_psel && i_penable && !i_pwrite;
	assign feat_word = P_FEAT_IMPL & ~(32'h1 << sipu_pkg::PCE_BIT);

	// ---------------------------------------------------------------
	// Operation execution
	// ---------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < sipu_pkg::NUM_CR; k++) begin
			cr_d[k] = cr_q[k];
		end
		glob_base_d = glob_base_q;
		glob_lim_d  = glob_lim_q;
		vect_base_d = vect_base_q;
		vect_lim_d  = vect_lim_q;
		loc_sel_d   = loc_sel_q;
		loc_desc_d  = loc_desc_q;
		task_sel_d  = task_sel_q;
		task_desc_d = task_desc_q;
		result_d    = result_q;
		done_d      = 1'b0;
		gp_d        = 1'b0;
		nm_d        = 1'b0;
		if (apb_wr && i_paddr == sipu_pkg::A_CR4) begin
			cr_d[4] = i_pwdata;
		end
		if (i_op_valid) begin
			done_d = 1'b1;
			// Refused operations change no state
			if (!allow) begin
				gp_d = 1'b1;
			end else begin
				case (i_op)
					sipu_pkg::OP_LD_GLOB: begin
						glob_base_d = i_operand[31:0];
						glob_lim_d  = i_operand[47:32];
					end
					sipu_pkg::OP_LD_VECT: begin
						vect_base_d = i_operand[31:0];
						vect_lim_d  = i_operand[47:32];
					end
					sipu_pkg::OP_ST_GLOB: begin
						result_d = {16'h0000, glob_lim_q, glob_base_q};
					end
					sipu_pkg::OP_ST_VECT: begin
						result_d = {16'h0000, vect_lim_q, vect_base_q};
					end
					sipu_pkg::OP_LD_LOCAL: begin
						loc_sel_d  = i_operand[15:0];
						loc_desc_d = i_desc;
					end
					sipu_pkg::OP_ST_LOCAL: begin
						result_d = {48'h0, loc_sel_q};
					end
					sipu_pkg::OP_LD_TASK: begin
						task_sel_d  = i_operand[15:0];
						task_desc_d = i_desc;
					end
					sipu_pkg::OP_ST_TASK: begin
						result_d = {48'h0, task_sel_q};
					end
					sipu_pkg::OP_LD_MSW: begin
						cr_d[0][sipu_pkg::MSW_W-1:0] = i_operand[15:0];
					end
					sipu_pkg::OP_ST_MSW: begin
						result_d = {48'h0, cr_q[0][sipu_pkg::MSW_W-1:0]};
					end
					sipu_pkg::OP_CLR_SW: begin
						cr_d[0][sipu_pkg::TS_BIT] = 1'b0;
					end
					sipu_pkg::OP_CR_LOAD: begin
						if (cr_ok) begin
							cr_d[i_cr_idx] = i_operand[31:0];
						end else begin
							gp_d = 1'b1;
						end
					end
					sipu_pkg::OP_CR_STORE: begin
						if (cr_ok) begin
							result_d = {32'h0, cr_q[i_cr_idx]};
						end else begin
							gp_d = 1'b1;
						end
					end
					sipu_pkg::OP_FPU: begin
						nm_d = cr_q[0][sipu_pkg::TS_BIT];
					end
					sipu_pkg::OP_FEAT_Q: begin
						result_d = {32'h0, feat_word};
					end
					default: begin
						result_d = result_q;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < sipu_pkg::NUM_CR; k++) begin
				cr_q[k] <= (k == 0) ? sipu_pkg::CR0_RST : sipu_pkg::CR_RST;
			end
			glob_base_q <= 32'h0;
			glob_lim_q  <= 16'hffff;
			vect_base_q <= 32'h0;
			vect_lim_q  <= 16'hffff;
			loc_sel_q   <= 16'h0;
			loc_desc_q  <= 64'h0;
			task_sel_q  <= 16'h0;
			task_desc_q <= 64'h0;
			result_q    <= 64'h0;
			done_q      <= 1'b0;
			gp_q        <= 1'b0;
			nm_q        <= 1'b0;
		end else begin
			for (int k = 0; k < sipu_pkg::NUM_CR; k++) begin
				cr_q[k] <= cr_d[k];
			end
			glob_base_q <= glob_base_d;
			glob_lim_q  <= glob_lim_d;
			vect_base_q <= vect_base_d;
			vect_lim_q  <= vect_lim_d;
			loc_sel_q   <= loc_sel_d;
			loc_desc_q  <= loc_desc_d;
			task_sel_q  <= task_sel_d;
			task_desc_q <= task_desc_d;
			result_q    <= result_d;
			done_q      <= done_d;
			gp_q        <= gp_d;
			nm_q        <= nm_d;
		end
	end

	// ---------------------------------------------------------------
	// Event status, mask and register reads
	// ---------------------------------------------------------------
	assign events = {nm_q, gp_q, done_q};

	always_comb begin
		stat_d  = stat_q | events;
		mask_d  = mask_q;
		rdata_d = rdata_q;
		// Set wins over the read clear
		if (apb_rd && i_paddr == sipu_pkg::A_STATUS) begin
			stat_d = events;
		end
		if (apb_wr && i_paddr == sipu_pkg::A_MASK) begin
			mask_d = i_pwdata[2:0];
		end
		// Read data prepared in the setup cycle
		if (i_psel && !i_penable) begin
			case (i_paddr)
				// Setup-cycle events folded in, so the clear loses none
				sipu_pkg::A_STATUS: rdata_d = {29'h0, stat_q | events};
				sipu_pkg::A_MASK:   rdata_d = {29'h0, mask_q};
				sipu_pkg::A_CR0:    rdata_d = cr_q[0];
				sipu_pkg::A_CR4:    rdata_d = cr_q[4];
				sipu_pkg::A_FEAT:   rdata_d = feat_word;
				default:            rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stat_q  <= 3'h0;
			mask_q  <= 3'h0;
			rdata_q <= 32'h0;
		end else begin
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// Unmapped addresses answer with a slave error
	always_comb begin
		case (i_paddr)
			sipu_pkg::A_STATUS,
			sipu_pkg::A_MASK,
			sipu_pkg::A_CR0,
			sipu_pkg::A_CR4,
			sipu_pkg::A_FEAT: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_op_done  = done_q;
	assign o_gp_fault = gp_q;
	assign o_nm_fault = nm_q;
	assign o_result   = result_q;
	assign o_cr0      = cr_q[0];
	assign o_cr4      = cr_q[4];
	assign o_prdata   = rdata_q;
	// Zero wait states: every access completes at once
	assign o_pready   = 1'b1;
	assign o_pslverr  = i_psel && i_penable && !addr_ok;
	assign o_irq      = |(stat_q & mask_q);
endmodule : sipu_top
`default_nettype wire

// ==== verification/sipu_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module sipu_top_assertions (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Operation request
	input  wire logic        i_op_valid,
	input  wire logic [4:0]  i_op,
	input  wire logic [1:0]  i_cpl,
	// Operation answer
	input  wire logic        o_op_done,
	input  wire logic        o_gp_fault,
	input  wire logic        o_nm_fault,
	input  wire logic [63:0] o_result,
	input  wire logic [31:0] o_cr0,
	input  wire logic [31:0] o_cr4
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	// Opcodes that need privilege zero
	localparam logic [31:0] PRIV = 32'h077c_1755;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	AST_DONE: assert property (i_op_valid |=> o_op_done)
		else $error("operation not answered");
	AST_IDLE: assert property (!i_op_valid |=> !o_op_done && $stable(o_result))
		else $error("answer or result change without request");
	AST_PRIV: assert property (i_op_valid && i_cpl != 2'h0 && PRIV[i_op] |=> o_gp_fault)
		else $error("privileged op not refused");
	AST_OPEN: assert property (i_op_valid && !PRIV[i_op] && i_op < 5'h1b |=> !o_gp_fault)
		else $error("unprivileged op refused");
	AST_CYC: assert property (i_op_valid && i_op == sipu_pkg::OP_CYC_RD |=>
		o_gp_fault == ($past(i_cpl) != 2'h0 && $past(o_cr4[sipu_pkg::TSD_BIT])))
		else $error("cycle counter read gating wrong");
	AST_EVT: assert property (i_op_valid && i_op == sipu_pkg::OP_EVT_RD |=>
		o_gp_fault == ($past(i_cpl) != 2'h0 && !$past(o_cr4[sipu_pkg::PCE_BIT])))
		else $error("event counter read gating wrong");
	AST_NM: assert property (i_op_valid && i_op == sipu_pkg::OP_FPU |=>
		o_nm_fault == $past(o_cr0[sipu_pkg::TS_BIT]))
		else $error("fpu fault wrong");
	AST_CLEAR_SWITCH_FLAG: assert property (i_op_valid && i_op == sipu_pkg::OP_CLR_SW && i_cpl == 2'h0 |=>
		!o_cr0[sipu_pkg::TS_BIT])
		else $error("switch flag not cleared");
	AST_MSW: assert property (i_op_valid && i_op == sipu_pkg::OP_LD_MSW |=>
		o_cr0[31:16] == $past(o_cr0[31:16]))
		else $error("status word load touched upper bits");
	AST_FLT: assert property (o_gp_fault || o_nm_fault |-> o_op_done)
		else $error("fault without done");

	cover property (i_op_valid && i_op == sipu_pkg::OP_CYC_RD && i_cpl == 2'h3);
	cover property (o_nm_fault);
	cover property (o_gp_fault);
endmodule : sipu_top_assertions

bind sipu_top sipu_top_assertions u_sipu_chk (.i_clk, .i_rst, .i_op_valid, .i_op, .i_cpl,
	.o_op_done, .o_gp_fault, .o_nm_fault, .o_result, .o_cr0, .o_cr4);
`default_nettype wire

// ==== verification/sipu_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module sipu_top_tb;
	// ---------------------------------------------------------------
	// Stimulus and observation
	// ---------------------------------------------------------------
	localparam logic [31:0] PRIV = 32'h077c_1755;
	logic        i_clk = 1'h0;
	logic        i_rst = 1'h1;
	logic        i_op_valid = 1'h0;
	logic [4:0]  i_op = 5'h00;
	logic [1:0]  i_cpl = 2'h0;
	logic [2:0]  i_cr_idx = 3'h0;
	logic [63:0] i_operand = 64'h0;
	logic [63:0] i_desc = 64'h0;
	logic        i_psel = 1'h0;
	logic        i_penable = 1'h0;
	logic        i_pwrite = 1'h0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic        o_op_done, o_gp_fault, o_nm_fault, o_pready, o_pslverr, o_irq;
	logic [63:0] o_result;
	logic [31:0] o_cr0, o_cr4, o_prdata, rd;
	logic        er, gp, nm;
	int          n_errors = 0;
	int          compares = 0;
	int          cyc = 0;

	sipu_top DUT (.i_clk, .i_rst, .i_op_valid, .i_op, .i_cpl, .i_cr_idx, .i_operand, .i_desc,
		.o_op_done, .o_gp_fault, .o_nm_fault, .o_result, .o_cr0, .o_cr4, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq);

	always #2 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic op(input logic [4:0] c, input logic [1:0] p, input logic [63:0] d,
		input logic [2:0] x);
		@(posedge i_clk);
		i_op_valid <= 1'h1;
		i_op <= c;
		i_cpl <= p;
		i_operand <= d;
		i_desc <= ~d;
		i_cr_idx <= x;
		@(posedge i_clk);
		i_op_valid <= 1'h0;
		#1;
		chk(o_op_done, 64'h1);
		gp = o_gp_fault;
		nm = o_nm_fault;
	endtask : op

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1'h1;
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'h1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		#1;
	endtask : apb

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'h0;
		#1;
		chk(o_cr0, 64'h10);
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 27; i++) begin
				op(i[4:0], p[1:0], 64'h0, 3'h0);
				chk(gp, p != 0 && PRIV[i]);
			end
		end
		$display("test privilege done");
		for (int f = 0; f < 4; f++) begin
			apb(1'h1, sipu_pkg::A_CR4, {23'h0, f[1], 5'h0, f[0], 2'h0});
			chk(o_cr4, {32'h0, 23'h0, f[1], 5'h0, f[0], 2'h0});
			for (int p = 0; p < 4; p++) begin
				op(sipu_pkg::OP_CYC_RD, p[1:0], 64'h0, 3'h0);
				chk(gp, p != 0 && f[0]);
				op(sipu_pkg::OP_EVT_RD, p[1:0], 64'h0, 3'h0);
				chk(gp, p != 0 && !f[1]);
			end
		end
		$display("test counters done");
		op(sipu_pkg::OP_LD_GLOB, 2'h0, 64'hffff_1234_89ab_cdef, 3'h0);
		op(sipu_pkg::OP_ST_GLOB, 2'h3, 64'h0, 3'h0);
		chk(o_result, 64'h0000_1234_89ab_cdef);
		op(sipu_pkg::OP_LD_VECT, 2'h2, 64'h0, 3'h0);
		chk(gp, 64'h1);
		op(sipu_pkg::OP_LD_VECT, 2'h0, 64'h0000_5555_0246_8ace, 3'h0);
		op(sipu_pkg::OP_ST_VECT, 2'h3, 64'h0, 3'h0);
		chk(o_result, 64'h0000_5555_0246_8ace);
		op(sipu_pkg::OP_LD_LOCAL, 2'h0, 64'hffff_ffff_ffff_a5c3, 3'h0);
		op(sipu_pkg::OP_ST_LOCAL, 2'h3, 64'h0, 3'h0);
		chk(o_result, 64'ha5c3);
		op(sipu_pkg::OP_LD_TASK, 2'h0, 64'h7777_0000_1111_3c5a, 3'h0);
		op(sipu_pkg::OP_ST_TASK, 2'h1, 64'h0, 3'h0);
		chk(o_result, 64'h3c5a);
		$display("test tables done");
		op(sipu_pkg::OP_CR_LOAD, 2'h0, 64'h5a5a_0008, 3'h0);
		chk(o_cr0, 64'h5a5a_0008);
		op(sipu_pkg::OP_FPU, 2'h3, 64'h0, 3'h0);
		chk(nm, 64'h1);
		op(sipu_pkg::OP_ST_MSW, 2'h3, 64'h0, 3'h0);
		chk(o_result, 64'h0008);
		op(sipu_pkg::OP_CLR_SW, 2'h0, 64'h0, 3'h0);
		chk(o_cr0, 64'h5a5a_0000);
		op(sipu_pkg::OP_FPU, 2'h3, 64'h0, 3'h0);
		chk(nm, 64'h0);
		op(sipu_pkg::OP_LD_MSW, 2'h0, 64'hffff_fff7, 3'h0);
		chk(o_cr0, 64'h5a5a_fff7);
		for (int x = 0; x < 6; x++) begin
			op(sipu_pkg::OP_CR_LOAD, 2'h0, {48'hc0de, 13'h0, x[2:0]}, x[2:0]);
			chk(gp, x > 4);
			op(sipu_pkg::OP_CR_STORE, 2'h0, 64'h0, x[2:0]);
			if (x < 5) chk(o_result, {48'hc0de, 13'h0, x[2:0]});
			else chk(gp, 64'h1);
		end
		op(sipu_pkg::OP_FEAT_Q, 2'h3, 64'h0, 3'h0);
		chk(o_result, {32'h0, sipu_pkg::FEAT_DEF & ~(32'h1 << sipu_pkg::PCE_BIT)});
		$display("test control words done");
		apb(1'h0, sipu_pkg::A_STATUS, 32'h0);
		apb(1'h1, sipu_pkg::A_MASK, 32'h4);
		op(sipu_pkg::OP_CR_LOAD, 2'h0, 64'h8, 3'h0);
		op(sipu_pkg::OP_FPU, 2'h0, 64'h0, 3'h0);
		apb(1'h1, sipu_pkg::A_CR0, 32'h0);
		apb(1'h0, sipu_pkg::A_CR0, 32'h0);
		chk(rd, 64'h8);
		chk(o_irq, 64'h1);
		apb(1'h0, sipu_pkg::A_STATUS, 32'h0);
		chk(rd, 64'h5);
		op(sipu_pkg::OP_LD_GLOB, 2'h3, 64'h0, 3'h0);
		apb(1'h0, sipu_pkg::A_MASK, 32'h0);
		chk(rd, 64'h4);
		chk(o_irq, 64'h0);
		apb(1'h0, sipu_pkg::A_STATUS, 32'h0);
		chk(rd, 64'h3);
		apb(1'h1, 8'h40, 32'hffff_ffff);
		chk(er, 64'h1);
		apb(1'h0, 8'h40, 32'h0);
		chk({er, rd}, 64'h1_0000_0000);
		apb(1'h0, sipu_pkg::A_CR4, 32'h0);
		chk(rd, 64'hc0de_0004);
		apb(1'h0, sipu_pkg::A_FEAT, 32'h0);
		chk(rd, {32'h0, sipu_pkg::FEAT_DEF & ~(32'h1 << sipu_pkg::PCE_BIT)});
		$display("test register bus done");
		@(posedge i_clk);
		i_rst <= 1'h1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'h0;
		#1;
		chk(o_cr0, 64'h10);
		$display("test second reset done");
		summarize();
	end
endmodule : sipu_top_tb
`default_nettype wire
